// ### verilog/flash_readout_protection.v
// Flash read-out, program and erase protection gate.
// Assumes core-side requests are one-cycle pulses synchronous to core_clk;
// the password store itself is a non-volatile value presented on nv_password.
`timescale 1ns/1ps
`include "flash_protect_defines.vh"

module flash_readout_protection (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [7:0] nv_password,
    input  wire [3:0] loader_mode,
    input  wire       pw_write,
    input  wire [7:0] pw_data,
    input  wire       pf_read_req,
    input  wire       df_read_req,
    input  wire [1:0] code_src,
    input  wire       pf_prog_req,
    input  wire       ext_req,
    output reg        pf_read_grant,
    output reg        df_read_grant,
    output reg        pf_prog_grant,
    output reg        ext_grant,
    output reg        access_denied,
    output reg  [7:0] stored_password,
    output reg  [1:0] prot_cfg
);

    ////////////////////////////////////////////////////////////////////////
    // Password capture

    reg        load_pending;
    wire [1:0] cfg_now;
    wire       pw_accept;

    // A write of zero is ignored: zero is never a valid password
    assign pw_accept = pw_write && (loader_mode == `LOADER_MODE_PW) && (pw_data != 8'h00);

    // Strap-style load one edge after reset release, not under reset itself
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_pending    <= 1'b1;
            stored_password <= `PW_RESET;
        end else if (load_pending) begin
            load_pending    <= 1'b0;
            stored_password <= nv_password;
        end else if (pw_accept) begin
            stored_password <= pw_data;
        end
    end

    protect_decode u_decode (
        .password (stored_password),
        .cfg      (cfg_now)
    );

    // Held configuration follows the stored password only
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prot_cfg <= `CFG_NONE;
        end else begin
            prot_cfg <= cfg_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decisions

    reg pf_rd_ok;
    reg df_rd_ok;
    reg pf_pg_ok;
    reg ext_ok;

    // Region checks per configuration; unknown regions treated as other
    always @* begin
        pf_rd_ok = 1'b1;
        df_rd_ok = 1'b1;
        pf_pg_ok = 1'b1;
        ext_ok   = 1'b1;
        case (prot_cfg)
            `CFG_NONE: begin
                ext_ok = 1'b1;
            end
            `CFG_READOUT: begin
                ext_ok = 1'b0;
            end
            `CFG_HW_MODE0: begin
                ext_ok   = 1'b0;
                pf_rd_ok = (code_src == `SRC_PFLASH);
                df_rd_ok = 1'b1;
                pf_pg_ok = 1'b0;
            end
            `CFG_HW_MODE1: begin
                ext_ok   = 1'b0;
                pf_rd_ok = (code_src == `SRC_PFLASH) || (code_src == `SRC_DFLASH);
                df_rd_ok = (code_src == `SRC_PFLASH) || (code_src == `SRC_DFLASH);
                pf_pg_ok = 1'b0;
            end
            default: begin
                ext_ok   = 1'b0;
                pf_rd_ok = 1'b0;
                df_rd_ok = 1'b0;
                pf_pg_ok = 1'b0;
            end
        endcase
    end

    // Registered grants; external port reaches program flash only with no protection configured
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pf_read_grant <= 1'b0;
            df_read_grant <= 1'b0;
            pf_prog_grant <= 1'b0;
            ext_grant     <= 1'b0;
            access_denied <= 1'b0;
        end else begin
            pf_read_grant <= pf_read_req && pf_rd_ok && !load_pending;
            df_read_grant <= df_read_req && df_rd_ok && !load_pending;
            pf_prog_grant <= pf_prog_req && pf_pg_ok && !load_pending;
            ext_grant     <= ext_req && ext_ok && !load_pending;
            access_denied <= (pf_read_req && !pf_rd_ok) || (df_read_req && !df_rd_ok)
                           || (pf_prog_req && !pf_pg_ok) || (ext_req && !ext_ok);
        end
    end

endmodule

// ### verilog/flash_protect_defines.vh
// Constants for the flash read-out and write protection block.
// Assumes inclusion by bare name from the design files; definitions only.
// What this block does
// - Protection turns on only when a non-zero 8-bit password is programmed in bootstrap_loader mode 6; zero is not a password.
// - While a valid password is stored, every external access path, flash included, is blocked.
// - Password bit 4 at zero leaves hardware protection off, with only read-out protection by password.
// - Password bit 4 at one with the top bit at zero selects hardware protection mode 0.
// - Password bit 4 at one with the top bit at one selects hardware protection mode 1.
// - Mode 0 protects the program flash and leaves the data flash open.
// - Mode 1 protects both the program flash and the data flash.
// - Program flash reads come from any code without hardware protection, from program flash code in mode 0, from either flash in mode 1.
// - External access to the program flash is refused in every configuration except no protection (zero password).
// - Program and erase of the program flash are allowed without hardware protection and rejected in both modes.
// - Data flash reads come from any code without hardware protection or in mode 0, from either flash code only in mode 1.
`ifndef FLASH_PROTECT_DEFINES_VH
`define FLASH_PROTECT_DEFINES_VH

`define PW_WIDTH          8
`define PW_HWPROT_BIT     4
`define PW_MODE_BIT       7
`define PW_RESET          8'h00
`define LOADER_MODE_PW    4'h6

// Protection configuration codes
`define CFG_NONE          2'h0
`define CFG_READOUT       2'h1
`define CFG_HW_MODE0      2'h2
`define CFG_HW_MODE1      2'h3

// Code source region of the requesting fetch
`define SRC_PFLASH        2'h0
`define SRC_DFLASH        2'h1
`define SRC_OTHER         2'h2

`endif

// ### verilog/protect_decode.v
// Decoder from stored password to protection configuration.
// Assumes a stable password input; purely combinational.
`timescale 1ns/1ps
`include "flash_protect_defines.vh"

module protect_decode (
    input  wire [7:0] password,
    output reg  [1:0] cfg
);

    // Zero password means no protection at all
    always @* begin
        if (password == 8'h00) begin
            cfg = `CFG_NONE;
        end else if (!password[`PW_HWPROT_BIT]) begin
            cfg = `CFG_READOUT;
        end else if (!password[`PW_MODE_BIT]) begin
            cfg = `CFG_HW_MODE0;
        end else begin
            cfg = `CFG_HW_MODE1;
        end
    end

endmodule

// ### sim/flash_readout_protection_chk.sv
// Checker bound onto the protection gate top.
// Assumes no request before the third edge after reset.
`timescale 1ns/1ps
module flash_readout_protection_chk (
    input logic       core_clk, rst, pw_write, pf_read_req, df_read_req, pf_prog_req, ext_req,
    input logic       pf_read_grant, df_read_grant, pf_prog_grant, ext_grant, access_denied,
    input logic [7:0] pw_data, stored_password,
    input logic [3:0] loader_mode,
    input logic [1:0] code_src, prot_cfg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Reference decisions from the held configuration
    wire pf_ok = prot_cfg < 2 || code_src == 0 || prot_cfg == 3 && code_src == 1;
    wire df_ok = prot_cfg != 3 || code_src < 2;
    wire [1:0] dec = stored_password == 0 ? 2'h0 : !stored_password[4] ? 2'h1 : {1'b1, stored_password[7]};
    wire bad = pf_read_req && !pf_ok || df_read_req && !df_ok || pf_prog_req && prot_cfg[1] || ext_req && prot_cfg != 0;
    ////////////////////////////////////////
    a_pf_rd_gate: assert property (##1 pf_read_grant == $past(pf_read_req && pf_ok)) else $error("pf read");
    a_df_rd_gate: assert property (df_read_req |=> df_read_grant == $past(df_ok)) else $error("df read");
    a_prog_gate: assert property (pf_prog_req |=> pf_prog_grant == !$past(prot_cfg[1])) else $error("prog");
    a_ext_block: assert property (ext_req && prot_cfg != 0 |=> !ext_grant && access_denied) else $error("ext");
    a_deny_flag: assert property (##1 access_denied == $past(bad)) else $error("deny");
    a_pw_ignore: assert property (pw_write && (pw_data == 0 || loader_mode != 6) |=> $stable(stored_password))
        else $error("pw kept");
    a_pw_load: assert property (pw_write && pw_data != 0 && loader_mode == 6 |=> stored_password == $past(pw_data))
        else $error("pw load");
    a_cfg_decode: assert property (##1 prot_cfg == $past(dec)) else $error("cfg");
    c_mode1_rd: cover property (prot_cfg == 3 && pf_read_req ##1 pf_read_grant);
    c_mode0_deny: cover property (prot_cfg == 2 && pf_prog_req ##1 access_denied);
    c_pw_load: cover property (pw_write && loader_mode == 6);
endmodule
bind flash_readout_protection flash_readout_protection_chk u_chk (.*);

// ### sim/req_source.sv
// Core and external host: bench commands become request pulses.
// Assumes go and op change just after a core_clk edge.
`timescale 1ns/1ps
module req_source (
    input  logic       core_clk, go,
    input  logic [3:0] op,
    output logic       pf_read_req, df_read_req, pf_prog_req, ext_req
);
    // Registered copy of op while go is high, so a held command repeats every cycle
    always @(posedge core_clk) {pf_read_req, df_read_req, pf_prog_req, ext_req} <= go ? op : 4'h0;
endmodule

// ### sim/flash_readout_protection_tb_top.sv
// Bench: swept and random requests per protection setting.
// Assumes the gate, checker and request source are compiled.
`timescale 1ns/1ps
module flash_readout_protection_tb_top;
    logic core_clk = 0, rst = 1, pw_write = 0, go = 0;
    logic [7:0] pw_data = 8'h00, nv_password = 8'h00, pw = 8'h00, stored_password;
    logic [3:0] loader_mode = 4'h0, op = 4'h0;
    logic [1:0] code_src = 2'h0, prot_cfg;
    logic pf_read_req, df_read_req, pf_prog_req, ext_req;
    logic pf_read_grant, df_read_grant, pf_prog_grant, ext_grant, access_denied;
    logic [7:0] pws [6] = '{8'h00, 8'h05, 8'h05, 8'h13, 8'h93, 8'h61};
    int error_cnt = 0, cmp_count = 0;
    flash_readout_protection u_flash_readout_protection (.*);
    req_source u_req_source (.*);
    initial forever #4 core_clk = ~core_clk;
    ////////////////////////////////////////
    function automatic [1:0] cfg_of(input [7:0] p);
        cfg_of = p == 0 ? 2'h0 : !p[4] ? 2'h1 : {1'b1, p[7]};
    endfunction
    // Grants then refusal flag
    function automatic [4:0] exp_of(input [1:0] c, input [3:0] o, input [1:0] s);
        logic [3:0] ok;
        ok = {c < 2 || s == 0 || c == 3 && s == 1, c != 3 || s < 2, c < 2, c == 0};
        exp_of = {o & ok, |(o & ~ok)};
    endfunction
    task automatic chk(input string nm, input [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input [7:0] d, input [3:0] m);
        @(posedge core_clk) {pw_write, pw_data, loader_mode} <= {1'b1, d, m};
        @(posedge core_clk) pw_write <= 0;
        if (d != 0 && m == 6) pw = d;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) chk("stored_password", pw, stored_password);
        chk("prot_cfg", cfg_of(pw), prot_cfg);
    endtask
    task automatic rq(input [3:0] o, input [1:0] s);
        @(posedge core_clk) {go, op, code_src} <= {1'b1, o, s};
        @(posedge core_clk) go <= 0;
        @(posedge core_clk);
        @(negedge core_clk) chk("grants", exp_of(cfg_of(pw), o, s), {pf_read_grant, df_read_grant,
            pf_prog_grant, ext_grant, access_denied});
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Sweep every setting, then random traffic
    initial begin
        void'($urandom(96));
        repeat (6) @(posedge core_clk);
        rst <= 0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) chk("prot_cfg", 8'h00, prot_cfg);
        foreach (pws[i]) begin
            wr(pws[i], i == 1 ? 4'h2 : 4'h6);
            for (int k = 0; k < 64; k++) rq(k[3:0], k[5:4]);
            $display("setting %h done", pw);
        end
        repeat (200) begin
            if ($urandom_range(9) == 0) wr(8'($urandom), 4'($urandom_range(6, 5)));
            rq(4'($urandom), 2'($urandom));
        end
        $display("random done");
        print_verdict();
    end
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule
